// [hdl/pcu_pkg.sv]
package pcu_pkg;
  // Register byte offsets
  localparam logic [7:0] PCU_OFF_RANDOM   = 8'h00;
  localparam logic [7:0] PCU_OFF_COUNT    = 8'h04;
  localparam logic [7:0] PCU_OFF_COMPARE  = 8'h08;
  localparam logic [7:0] PCU_OFF_STATUS   = 8'h0C;
  localparam logic [7:0] PCU_OFF_CAUSE    = 8'h10;
  localparam logic [7:0] PCU_OFF_ERRPC_LO = 8'h14;
  localparam logic [7:0] PCU_OFF_ERRPC_HI = 8'h18;
  localparam logic [7:0] PCU_OFF_WLO0     = 8'h20;
  localparam logic [7:0] PCU_OFF_WHI0     = 8'h24;
  localparam logic [7:0] PCU_OFF_WLO1     = 8'h28;
  localparam logic [7:0] PCU_OFF_WHI1     = 8'h2C;
  localparam logic [7:0] PCU_OFF_SETUP    = 8'h30;
  localparam logic [7:0] PCU_OFF_PGMASK   = 8'h34;
  // Field positions
  localparam int PCU_ST_IE   = 0;
  localparam int PCU_ST_EXL  = 1;
  localparam int PCU_ST_ERL  = 2;
  localparam int PCU_ST_UX   = 5;
  localparam int PCU_CA_IP7  = 15;
  localparam int PCU_CA_HW5  = 7;
  localparam int PCU_CA_MM   = 8;
  localparam int PCU_CA_WP   = 9;
  localparam int PCU_CA_MC   = 10;
  localparam int PCU_CA_BE   = 11;
  localparam int PCU_CA_CE   = 12;
  localparam int PCU_CA_NMI  = 13;
  localparam int PCU_SETUP_HOLD = 1;
  // Widths and other constants
  localparam int PCU_SEG_W  = 44;
  localparam int PCU_PA_W   = 40;
  localparam int PCU_LOW_W  = 31;
  localparam int PCU_SKIP_N = 3;
  localparam logic [7:0]  PCU_PGMASK_MAX = 8'hFF;
  localparam logic [31:0] PCU_SETUP_RST  = 32'h0000_0002;
  localparam logic [63:0] PCU_PC_STEP    = 64'h0000_0000_0000_0004;
  localparam logic [2:0]  PCU_ATTR_UNC   = 3'h2;
  // Pipeline event bundle
  typedef struct packed {
    logic        grad;
    logic        tlbw;
    logic        tlb_dup;
    logic        tlb_fault;
    logic        bus_tmo;
    logic        dbus_err;
    logic        dcache_err;
    logic        nmi;
    logic        err_exc;
    logic        in_delay;
    logic        watch_hit;
    logic        watch_prefcache;
    logic        low_exc;
    logic        wait_op;
    logic [63:0] pc;
  } pcu_evt_t;
  // Translation result bundle
  typedef struct packed {
    logic                mapped;
    logic [2:0]          attr;
    logic [PCU_PA_W-1:0] pa;
  } pcu_xlat_t;
endpackage

// [hdl/pcu_top.sv]
`timescale 1ns/1ps
module pcu_top
  import pcu_pkg::*;
#(
  parameter int ENTRIES = 64,
  parameter int IDX_W   = $clog2(ENTRIES)
)(
  input  wire logic            ref_clk_in,
  input  wire logic            resetn_in,
  input  wire logic [7:0]      avs_address_in,
  input  wire logic            avs_read_in,
  input  wire logic            avs_write_in,
  input  wire logic [31:0]     avs_writedata_in,
  input  wire logic [3:0]      avs_byteenable_in,
  input  wire pcu_evt_t        evt_in,
  input  wire logic            hw_int5_in,
  input  wire logic [63:0]     va_in,
  input  wire logic            va_valid_in,
  output logic [31:0]          avs_readdata_out,
  output logic                 avs_waitrequest_out,
  output logic                 avs_response_out,
  output logic [IDX_W-1:0]     random_index_out,
  output logic                 timer_interrupt_pending_bit_out,
  output logic                 int_req_out,
  output logic                 machine_check_out,
  output logic                 imprecise_err_out,
  output logic                 nmi_take_out,
  output logic                 watch_take_out,
  output pcu_xlat_t            xlat_out,
  output logic                 core1_reset_out
);
  // Sum of all state but the reset synchroniser
  typedef struct packed {
    logic [IDX_W-1:0]    random_q;
    logic [1:0]          skip_q;
    logic [31:0]         count_q;
    logic [31:0]         compare_q;
    logic [31:0]         status_q;
    logic [31:0]         cause_q;
    logic [63:0]         error_return_pc_q;
    logic [31:0]         wlo0_q;
    logic [31:0]         whi0_q;
    logic [31:0]         wlo1_q;
    logic [31:0]         whi1_q;
    logic [31:0]         setup_q;
    logic [7:0]          pgmask_q;
    logic [31:0]         rdata_q;
    logic                ack_q;
    logic                resp_q;
    logic                intr_q;
    logic                mc_q;
    logic                imp_q;
    logic                nmi_q;
    logic                watch_q;
    pcu_xlat_t           xlat_q;
  } pcu_state_t;

  pcu_state_t s_q;           // Registered state
  pcu_state_t s_d;           // Next state
  logic       rst_n;         // Synchronised reset
  logic       access;        // Bus access present
  logic [1:0] rst_sync_q;    // Reset release stages
  logic [31:0] cause_set;    // Sticky cause bits raised this cycle

  assign rst_n  = rst_sync_q[1];
  assign access = (avs_read_in | avs_write_in) & ~s_q.ack_q;

  // Byte-enable merge of a written word
  function automatic logic [31:0] pcu_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // Reset synchroniser, constants only under async reset
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // Next-state logic
  always_comb
  begin
    s_d          = s_q;
    cause_set    = 32'h0000_0000;
    s_d.ack_q    = access;
    s_d.count_q = s_q.count_q + 32'h0000_0001;
    if (evt_in.grad)
    begin
      if (evt_in.tlbw)
      begin
        if (s_q.skip_q == 2'(PCU_SKIP_N - 1))
          s_d.skip_q = 2'h0;
        else
        begin
          s_d.skip_q   = s_q.skip_q + 2'h1;
          s_d.random_q = s_q.random_q + IDX_W'(1);
        end
      end
      else
        s_d.random_q = s_q.random_q + IDX_W'(1);
    end
    s_d.cause_q[PCU_CA_HW5] = hw_int5_in;
    if (s_q.count_q == s_q.compare_q)
      s_d.cause_q[PCU_CA_IP7] = 1'b1;
    s_d.intr_q = (s_d.cause_q[PCU_CA_IP7] | hw_int5_in) & s_q.status_q[PCU_ST_IE]
                 & ~s_q.status_q[PCU_ST_EXL] & ~s_q.status_q[PCU_ST_ERL];
    if (evt_in.err_exc)
      s_d.error_return_pc_q = evt_in.in_delay ? (evt_in.pc - PCU_PC_STEP) : evt_in.pc;
    s_d.mc_q = evt_in.tlb_fault | evt_in.bus_tmo | (evt_in.tlbw & evt_in.tlb_dup);
    if (s_d.mc_q)
      cause_set[PCU_CA_MC] = 1'b1;
    if (evt_in.tlbw & evt_in.tlb_dup)
      cause_set[PCU_CA_MM] = 1'b1;
    s_d.imp_q = evt_in.dbus_err | evt_in.dcache_err;
    if (evt_in.dbus_err)
      cause_set[PCU_CA_BE] = 1'b1;
    if (evt_in.dcache_err)
      cause_set[PCU_CA_CE] = 1'b1;
    s_d.nmi_q = evt_in.nmi;
    if (evt_in.nmi)
      cause_set[PCU_CA_NMI] = 1'b1;
    s_d.watch_q = 1'b0;
    if (evt_in.watch_hit & ~evt_in.watch_prefcache)
    begin
      if (s_q.status_q[PCU_ST_EXL] | s_q.status_q[PCU_ST_ERL])
      begin
        if (!evt_in.low_exc)
          cause_set[PCU_CA_WP] = 1'b1;
      end
      else
        s_d.watch_q = 1'b1;
    end
    // Raise the sticky cause bits of this cycle
    s_d.cause_q = s_d.cause_q | cause_set;
    // wait is a no-op (evt_in.wait_op ignored)
    s_d.xlat_q.mapped = 1'b1;
    s_d.xlat_q.attr   = 3'h0;
    s_d.xlat_q.pa     = '0;
    if (va_valid_in & s_q.status_q[PCU_ST_ERL])
    begin
      if (va_in[63:PCU_LOW_W] == '0)
      begin
        s_d.xlat_q.mapped = 1'b0;
        s_d.xlat_q.attr   = PCU_ATTR_UNC;
        s_d.xlat_q.pa     = {{(PCU_PA_W-32){1'b0}}, va_in[31:0]};
      end
      else if (s_q.status_q[PCU_ST_UX] && va_in[63:PCU_SEG_W] == '0)
      begin
        s_d.xlat_q.mapped = 1'b0;
        s_d.xlat_q.attr   = PCU_ATTR_UNC;
        s_d.xlat_q.pa     = {{(PCU_PA_W-32){1'b0}}, va_in[31:0]};
      end
    end
    // Register reads and writes
    s_d.resp_q = 1'b0;
    if (access & avs_write_in)
    begin
      case (avs_address_in)
        PCU_OFF_COUNT:    s_d.count_q = pcu_merge(s_q.count_q, avs_writedata_in,
                                                  avs_byteenable_in);
        PCU_OFF_COMPARE:
        begin
          s_d.compare_q = pcu_merge(s_q.compare_q, avs_writedata_in, avs_byteenable_in);
          s_d.cause_q[PCU_CA_IP7] = (s_q.count_q == s_q.compare_q);
        end
        PCU_OFF_STATUS:   s_d.status_q = pcu_merge(s_q.status_q, avs_writedata_in,
                                                   avs_byteenable_in);
        // Cause sticky bits write one to clear, set wins
        PCU_OFF_CAUSE:    s_d.cause_q = (s_d.cause_q & ~(avs_writedata_in & 32'h0000_3F00))
                                        | cause_set;
        PCU_OFF_WLO0:     s_d.wlo0_q = pcu_merge(s_q.wlo0_q, avs_writedata_in,
                                                 avs_byteenable_in);
        PCU_OFF_WHI0:     s_d.whi0_q = pcu_merge(s_q.whi0_q, avs_writedata_in,
                                                 avs_byteenable_in);
        PCU_OFF_WLO1:     s_d.wlo1_q = pcu_merge(s_q.wlo1_q, avs_writedata_in,
                                                 avs_byteenable_in);
        PCU_OFF_WHI1:     s_d.whi1_q = pcu_merge(s_q.whi1_q, avs_writedata_in,
                                                 avs_byteenable_in);
        PCU_OFF_SETUP:    s_d.setup_q = pcu_merge(s_q.setup_q, avs_writedata_in,
                                                  avs_byteenable_in);
        PCU_OFF_PGMASK:   s_d.pgmask_q = avs_writedata_in[7:0] & PCU_PGMASK_MAX;
        PCU_OFF_RANDOM, PCU_OFF_ERRPC_LO, PCU_OFF_ERRPC_HI: s_d.resp_q = 1'b0;
        default:          s_d.resp_q = 1'b1;
      endcase
    end
    s_d.rdata_q = 32'h0000_0000;
    if (access & avs_read_in)
    begin
      case (avs_address_in)
        PCU_OFF_RANDOM:   s_d.rdata_q = 32'(s_q.random_q);
        PCU_OFF_COUNT:    s_d.rdata_q = s_q.count_q;
        PCU_OFF_COMPARE:  s_d.rdata_q = s_q.compare_q;
        PCU_OFF_STATUS:   s_d.rdata_q = s_q.status_q;
        PCU_OFF_CAUSE:    s_d.rdata_q = s_q.cause_q;
        PCU_OFF_ERRPC_LO: s_d.rdata_q = s_q.error_return_pc_q[31:0];
        PCU_OFF_ERRPC_HI: s_d.rdata_q = s_q.error_return_pc_q[63:32];
        PCU_OFF_WLO0:     s_d.rdata_q = s_q.wlo0_q;
        PCU_OFF_WHI0:     s_d.rdata_q = s_q.whi0_q;
        PCU_OFF_WLO1:     s_d.rdata_q = s_q.wlo1_q;
        PCU_OFF_WHI1:     s_d.rdata_q = s_q.whi1_q;
        PCU_OFF_SETUP:    s_d.rdata_q = s_q.setup_q;
        PCU_OFF_PGMASK:   s_d.rdata_q = {24'h00_0000, s_q.pgmask_q};
        default:          s_d.resp_q  = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.random_q          <= {IDX_W{1'b1}};
      s_q.skip_q            <= 2'h0;
      s_q.count_q           <= 32'h0000_0000;
      s_q.compare_q         <= 32'h0000_0000;
      s_q.status_q          <= 32'h0000_0004;
      s_q.cause_q           <= 32'h0000_0000;
      s_q.error_return_pc_q <= 64'h0000_0000_0000_0000;
      s_q.wlo0_q            <= 32'h0000_0000;
      s_q.whi0_q            <= 32'h0000_0000;
      s_q.wlo1_q            <= 32'h0000_0000;
      s_q.whi1_q            <= 32'h0000_0000;
      s_q.setup_q           <= PCU_SETUP_RST;
      s_q.pgmask_q          <= 8'h00;
      s_q.rdata_q           <= 32'h0000_0000;
      s_q.ack_q             <= 1'b0;
      s_q.resp_q            <= 1'b0;
      s_q.intr_q            <= 1'b0;
      s_q.mc_q              <= 1'b0;
      s_q.imp_q             <= 1'b0;
      s_q.nmi_q             <= 1'b0;
      s_q.watch_q           <= 1'b0;
      s_q.xlat_q            <= '0;
    end
    else
    begin
      s_q.random_q          <= s_d.random_q;
      s_q.skip_q            <= s_d.skip_q;
      s_q.count_q           <= s_d.count_q;
      s_q.compare_q         <= s_d.compare_q;
      s_q.status_q          <= s_d.status_q;
      s_q.cause_q           <= s_d.cause_q;
      s_q.error_return_pc_q <= s_d.error_return_pc_q;
      s_q.wlo0_q            <= s_d.wlo0_q;
      s_q.whi0_q            <= s_d.whi0_q;
      s_q.wlo1_q            <= s_d.wlo1_q;
      s_q.whi1_q            <= s_d.whi1_q;
      s_q.setup_q           <= s_d.setup_q;
      s_q.pgmask_q          <= s_d.pgmask_q;
      s_q.rdata_q           <= s_d.rdata_q;
      s_q.ack_q             <= s_d.ack_q;
      s_q.resp_q            <= s_d.resp_q;
      s_q.intr_q            <= s_d.intr_q;
      s_q.mc_q              <= s_d.mc_q;
      s_q.imp_q             <= s_d.imp_q;
      s_q.nmi_q             <= s_d.nmi_q;
      s_q.watch_q           <= s_d.watch_q;
      s_q.xlat_q            <= s_d.xlat_q;
    end
  end

  // Outputs straight from flops
  assign avs_readdata_out                = s_q.rdata_q;
  assign avs_waitrequest_out             = ~s_q.ack_q;
  assign avs_response_out                = s_q.resp_q;
  assign random_index_out                = s_q.random_q;
  assign timer_interrupt_pending_bit_out = s_q.cause_q[PCU_CA_IP7];
  assign int_req_out                     = s_q.intr_q;
  assign machine_check_out               = s_q.mc_q;
  assign imprecise_err_out               = s_q.imp_q;
  assign nmi_take_out                    = s_q.nmi_q;
  assign watch_take_out                  = s_q.watch_q;
  assign xlat_out                        = s_q.xlat_q;
  assign core1_reset_out                 = s_q.setup_q[PCU_SETUP_HOLD];
endmodule // pcu_top

// [testbench/pcu_top_sva.sv]
`timescale 1ns/1ps
// Port-level checks of the privileged control unit
module pcu_top_sva
  import pcu_pkg::*;
#(
  parameter int ENTRIES = 64,
  parameter int IDX_W   = $clog2(ENTRIES)
)(
  input wire logic             ref_clk_in,
  input wire logic             resetn_in,
  input wire logic [7:0]       avs_address_in,
  input wire logic             avs_write_in,
  input wire logic [31:0]      avs_writedata_in,
  input wire pcu_evt_t         evt_in,
  input wire logic [IDX_W-1:0] random_index_out,
  input wire logic             timer_interrupt_pending_bit_out,
  input wire logic             machine_check_out,
  input wire logic             imprecise_err_out,
  input wire logic             nmi_take_out,
  input wire logic             watch_take_out,
  input wire logic             core1_reset_out
);
  // One clock domain, board reset disables all checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // Plain graduation steps the index by one
  rand_step_a: assert property (evt_in.grad && !evt_in.tlbw |=>
    random_index_out == $past(random_index_out) + 1'b1) else $error("index did not step");
  // No graduation, no movement
  rand_hold_a: assert property (!evt_in.grad |=> $stable(random_index_out))
    else $error("index moved while idle");
  // Fault or time-out gives a machine check
  mchk_raise_a: assert property (evt_in.tlb_fault || evt_in.bus_tmo |=> machine_check_out)
    else $error("machine check missing");
  // A machine check always has a cause
  mchk_cause_a: assert property (machine_check_out |->
    $past(evt_in.tlb_fault || evt_in.bus_tmo || evt_in.tlb_dup)) else $error("stray machine check");
  // Data bus and cache errors reported imprecisely
  impr_raise_a: assert property (evt_in.dbus_err || evt_in.dcache_err |=> imprecise_err_out)
    else $error("imprecise error missing");
  // Single nonmaskable event gives a single pulse
  nmi_pulse_a: assert property (evt_in.nmi ##1 !evt_in.nmi |-> nmi_take_out ##1 !nmi_take_out)
    else $error("nmi pulse wrong");
  // Prefetch and cache operations never watch
  watch_quiet_a: assert property (evt_in.watch_hit && evt_in.watch_prefcache |=> !watch_take_out)
    else $error("watch taken on prefetch");
  // Second core leaves reset only on a setup write
  core1_go_a: assert property ($fell(core1_reset_out) |-> $past(avs_write_in &&
    avs_address_in == PCU_OFF_SETUP && !avs_writedata_in[PCU_SETUP_HOLD])) else $error("core1 freed");
  // Timer pending clears only on a compare write
  tip_hold_a: assert property ($fell(timer_interrupt_pending_bit_out) |->
    $past(avs_write_in && avs_address_in == PCU_OFF_COMPARE)) else $error("pending lost");
  // Main scenarios reached
  tip_c: cover property ($rose(timer_interrupt_pending_bit_out));
  core1_c: cover property ($fell(core1_reset_out));
  mchk_c: cover property (machine_check_out);
endmodule // pcu_top_sva
bind pcu_top pcu_top_sva #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_sva (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .evt_in(evt_in),
  .random_index_out(random_index_out),
  .timer_interrupt_pending_bit_out(timer_interrupt_pending_bit_out),
  .machine_check_out(machine_check_out), .imprecise_err_out(imprecise_err_out),
  .nmi_take_out(nmi_take_out), .watch_take_out(watch_take_out),
  .core1_reset_out(core1_reset_out));

// [testbench/pcu_pipe_model.sv]
`timescale 1ns/1ps
// Pipeline stand-in: replays one event set for a number of cycles
module pcu_pipe_model
  import pcu_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       go_in,
  input  wire logic [7:0] n_in,
  input  wire pcu_evt_t   tpl_in,
  output pcu_evt_t        evt_out,
  output logic            busy_out
);
  logic [7:0] cnt_q; // Cycles left in the burst
  pcu_evt_t   tpl_q; // Event set held for the burst
  // Load on go, then count down
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cnt_q <= 8'h00;
    else if (go_in)
    begin
      cnt_q <= n_in;
      tpl_q <= tpl_in;
    end
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  // Idle pipeline: nothing graduates, no event
  assign evt_out  = (cnt_q != 8'h00) ? tpl_q : '0;
  assign busy_out = (cnt_q != 8'h00);
endmodule // pcu_pipe_model

// [testbench/tb_privileged_control_unit.sv]
`timescale 1ns/1ps
// Bench: bus tasks reach the registers, the pipeline model replays events
module tb_privileged_control_unit
  import pcu_pkg::*;
();
  logic        clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, hw5 = 1'b0, va_v = 1'b0;
  logic        go = 1'b0, wreq, resp, rsp, tip, irq, core1, busy;
  logic [7:0]  addr = 8'h00, n_req = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q, q2;
  logic [63:0] va = 64'h0;
  logic [5:0]  ridx, ri_e;       // Index seen and expected
  logic [2:0]  fl;               // Levels awaited by the bench
  pcu_evt_t    evt, t, tpl = '0;
  pcu_xlat_t   xl;
  int          fails = 0, n_compared = 0;
  assign fl = {~core1, irq, tip};
  // Core clock, 40 ns period
  always #20 clk = ~clk;
  pcu_top dut (.ref_clk_in(clk), .resetn_in(resetn), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .evt_in(evt), .hw_int5_in(hw5), .va_in(va), .va_valid_in(va_v),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .avs_response_out(resp),
    .random_index_out(ridx), .timer_interrupt_pending_bit_out(tip), .int_req_out(irq),
    .machine_check_out(), .imprecise_err_out(), .nmi_take_out(), .watch_take_out(),
    .xlat_out(xl), .core1_reset_out(core1));
  pcu_pipe_model pipe (.clk_in(clk), .resetn_in(resetn), .go_in(go), .n_in(n_req),
    .tpl_in(tpl), .evt_out(evt), .busy_out(busy));
  // Verdict and end of run
  task automatic summarize();
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Value comparison
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Exhausted wait ends the run
  task automatic tmo(input string nm, input int i, input int lim);
    if (i >= lim)
    begin
      fails++;
      $display("unexpected %s expected answer seen none", nm);
      summarize();
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd    <= ~w;
    wr    <= w;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (wreq === 1'b0)
        break;
    end
    r = rdata;
    rsp = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    tmo("bus answer", i, 100);
  endtask
  // Write, then let its effect land
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
    @(posedge clk);
  endtask
  // Read and compare under a mask
  task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    cmp(nm, e & m, r & m);
  endtask
  // Replay an event set for n cycles
  task automatic burst(input pcu_evt_t e, input logic [7:0] n);
    int i;
    tpl   <= e;
    n_req <= n;
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 300 && (i < 2 || busy === 1'b1); i++)
      @(posedge clk);
    tmo("burst end", i, 300);
  endtask
  // Wait for a level to rise
  task automatic await(input string nm, input int b);
    int i;
    for (i = 0; i < 100 && fl[b] !== 1'b1; i++)
      @(posedge clk);
    tmo(nm, i, 100);
    cmp(nm, 64'h1, fl[b]);
  endtask
  // Translation with the error level set
  task automatic xchk(input logic [63:0] v, input logic [39:0] p);
    va   <= v;
    va_v <= 1'b1;
    @(posedge clk);
    va_v <= 1'b0;
    @(posedge clk);
    cmp("xlat", {1'b0, PCU_ATTR_UNC, p}, xl);
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("core1 held", 64'h1, core1);
    chk("status", PCU_OFF_STATUS, 32'hFFFF_FFFF, 32'h4);
    chk("setup", PCU_OFF_SETUP, 32'hFFFF_FFFF, PCU_SETUP_RST);
    wreg(PCU_OFF_WLO0, 32'h1111_1110);
    wreg(PCU_OFF_WLO1, 32'h2222_2220);
    chk("watch 0", PCU_OFF_WLO0, 32'hFFFF_FFFF, 32'h1111_1110);
    chk("watch 1", PCU_OFF_WLO1, 32'hFFFF_FFFF, 32'h2222_2220);
    acc(1'b0, 8'h3C, 32'h0, q);
    cmp("unmapped", 33'h1_0000_0000, {rsp, q});
    acc(1'b0, PCU_OFF_COUNT, 32'h0, q);
    acc(1'b0, PCU_OFF_COUNT, 32'h0, q2);
    cmp("count step", q + 32'h3, q2);
    ri_e = 6'h3F + 6'h0A;
    t = '{grad: 1'b1, default: '0};
    burst(t, 8'h0A);
    cmp("random", ri_e, ridx);
    t.tlbw = 1'b1;
    burst(t, 8'h06);
    cmp("random", ri_e + 6'h04, ridx);
    t = '{tlb_fault: 1'b1, bus_tmo: 1'b1, tlbw: 1'b1, tlb_dup: 1'b1, dbus_err: 1'b1,
          dcache_err: 1'b1,
          nmi: 1'b1, watch_hit: 1'b1, watch_prefcache: 1'b1, low_exc: 1'b1, default: '0};
    burst(t, 8'h01);
    chk("cause", PCU_OFF_CAUSE, 32'h3F00, 32'h3D00);
    wreg(PCU_OFF_CAUSE, 32'h3F00);
    chk("cause clear", PCU_OFF_CAUSE, 32'h3F00, 32'h0);
    for (int d = 0; d < 2; d++)
    begin
      t = '{err_exc: 1'b1, in_delay: d[0], pc: 64'h0000_00AB_0000_1000, default: '0};
      burst(t, 8'h01);
      chk("errpc lo", PCU_OFF_ERRPC_LO, 32'hFFFF_FFFF, d ? 32'h0FFC : 32'h1000);
      chk("errpc hi", PCU_OFF_ERRPC_HI, 32'hFFFF_FFFF, 32'hAB);
    end
    wreg(PCU_OFF_STATUS, 32'h4);
    xchk(64'h0000_0000_7654_3210, 40'h00_7654_3210);
    wreg(PCU_OFF_STATUS, 32'h24);
    xchk(64'h0000_0ABC_8765_4321, 40'h00_8765_4321);
    acc(1'b0, PCU_OFF_COUNT, 32'h0, q);
    wreg(PCU_OFF_COMPARE, q + 32'h28);
    cmp("pending", 64'h0, tip);
    await("timer pending", 0);
    cmp("masked request", 64'h0, irq);
    wreg(PCU_OFF_STATUS, 32'h1);
    await("request", 1);
    wreg(PCU_OFF_COMPARE, q);
    cmp("pending", 64'h0, tip);
    hw5 <= 1'b1;
    await("line 5 request", 1);
    chk("cause line 5", PCU_OFF_CAUSE, 32'h80, 32'h80);
    hw5 <= 1'b0;
    wreg(PCU_OFF_SETUP, 32'h0);
    await("core1 release", 2);
    summarize();
  end
endmodule // tb_privileged_control_unit
